// ---- chan_four_pkg.sv ----
// Constants and types for the output channel four control block
// Behaviour
// - Source codes: 0 PLL, 2 primary, 3 secondary
// - Driver type: off, AC style, HCSL, LVCMOS
// - Mode one: tail current, or positive leg
// - Code three: 16 mA HCSL, 8 mA AC
// - Mode two: HCSL load, or negative leg
// - Divide ratio equals divider field plus one
// - Divider only for PLL; references bypass it
// - Reset values: control 0x18, divider 0x02
// - Doubler enabled: references deliver doubled frequency
package chan_four_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] CTL_IDX = 8'h25;
   localparam logic [7:0] DIV_IDX = 8'h26;
   localparam logic [31:0] CTL_ADDR = 32'({CTL_IDX, 2'h0});
   localparam logic [31:0] DIV_ADDR = 32'({DIV_IDX, 2'h0});
   // Control register field positions (low bit of each two-bit field)
   localparam int SRC_LSB = 6;
   localparam int TYPE_LSB = 4;
   localparam int MODE1_LSB = 2;
   localparam int MODE2_LSB = 0;
   // Reset values
   localparam logic [1:0] SRC_RST = 2'h0;
   localparam logic [1:0] TYPE_RST = 2'h1;
   localparam logic [1:0] MODE1_RST = 2'h2;
   localparam logic [1:0] MODE2_RST = 2'h0;
   localparam logic [7:0] CTL_RST = {SRC_RST, TYPE_RST, MODE1_RST, MODE2_RST};
   localparam logic [7:0] DIV_RST = 8'h02;
   // Tail currents in mA
   localparam logic [4:0] TAIL_4MA = 5'h04;
   localparam logic [4:0] TAIL_6MA = 5'h06;
   localparam logic [4:0] TAIL_8MA = 5'h08;
   localparam logic [4:0] TAIL_16MA = 5'h10;
   // HCSL load in ohms, zero meaning tristate
   localparam logic [7:0] LOAD_OFF = 8'h00;
   localparam logic [7:0] LOAD_50 = 8'h32;
   localparam logic [7:0] LOAD_100 = 8'h64;
   localparam logic [7:0] LOAD_200 = 8'hc8;
   // AHB transfer type bit that marks an active transfer
   localparam int HTRANS_ACTIVE_BIT = 1;
   // Channel clock source
   typedef enum logic [1:0] {
      SRC_PLL = 2'b00,
      SRC_RSVD = 2'b01,
      SRC_PRI = 2'b10,
      SRC_SEC = 2'b11
   } src_t;
   // Output driver type
   typedef enum logic [1:0] {
      DRV_OFF = 2'b00,
      DRV_AC = 2'b01,
      DRV_HCSL = 2'b10,
      DRV_CMOS = 2'b11
   } drv_t;
endpackage : chan_four_pkg

// ---- chan_source_mux.sv ----
// Clock source selection for channel four, with doubled references
`timescale 1ns/1ps
module chan_source_mux (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire chan_four_pkg::src_t src_i,
   input wire logic dbl_en_i,
   input wire logic pll_tick_i,
   input wire logic pri_tick_i,
   input wire logic sec_tick_i,
   input wire logic pri_x2_tick_i,
   input wire logic sec_x2_tick_i,
   output logic tick_o,
   output logic bypass_o
);
   import chan_four_pkg::*;

   // Pick one source tick; reserved code passes nothing
   always_comb begin
      tick_o = 1'b0;
      bypass_o = 1'b1;
      case (src_i)
         SRC_PLL: begin
            tick_o = pll_tick_i;
            bypass_o = 1'b0;
         end
         SRC_PRI: begin
            tick_o = dbl_en_i ? pri_x2_tick_i : pri_tick_i;
         end
         SRC_SEC: begin
            tick_o = dbl_en_i ? sec_x2_tick_i : sec_tick_i;
         end
         default: begin
            tick_o = 1'b0;
         end
      endcase
   end

   a_pri_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (src_i == SRC_PRI && !dbl_en_i) |-> (tick_o == pri_tick_i && bypass_o))
      else $error("primary reference not routed");
   a_dbl_route: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (src_i == SRC_SEC && dbl_en_i) |-> (tick_o == sec_x2_tick_i))
      else $error("doubled secondary reference not routed");
endmodule : chan_source_mux

// ---- chan_divider.sv ----
// Programmable output divider, ratio is field value plus one
`timescale 1ns/1ps
module chan_divider #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic tick_i,
   input wire logic bypass_i,
   input wire logic [WIDTH-1:0] div_i,
   output logic tick_o
);
   import chan_four_pkg::*;

   logic [WIDTH-1:0] cnt_q; // Input ticks seen in this output period

   // Count input ticks; >= keeps a shrunk ratio from running away
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_q <= '0;
      end else if (bypass_i) begin
         cnt_q <= '0;
      end else if (tick_i) begin
         if (cnt_q >= div_i) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // Registered output tick, one cycle behind the input
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tick_o <= 1'b0;
      end else if (bypass_i) begin
         tick_o <= tick_i;
      end else begin
         tick_o <= tick_i && (cnt_q >= div_i);
      end
   end

   a_bypass_pass: assert property (@(posedge clk_i) disable iff (!nrst_i)
      bypass_i |=> (tick_o == $past(tick_i)))
      else $error("bypassed tick not passed through");
   a_div_ratio: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (!bypass_i && tick_i && cnt_q < div_i) |=> !tick_o)
      else $error("divider fired before ratio reached");
   a_div_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (!bypass_i && tick_i && cnt_q == div_i && $stable(div_i)) |=> (tick_o && cnt_q == '0))
      else $error("divider missed its terminal count");
endmodule : chan_divider

// ---- output_channel_four_control.sv ----
// Channel four control registers over AHB-Lite, source mux and divider
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module output_channel_four_control #(
   parameter int DIV_WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Source ticks, one cycle per source clock edge
   input wire logic dbl_en_i,
   input wire logic pll_tick_i,
   input wire logic pri_tick_i,
   input wire logic sec_tick_i,
   input wire logic pri_x2_tick_i,
   input wire logic sec_x2_tick_i,
   // Channel output and driver settings
   output logic chan_tick_o,
   output logic drv_en_o,
   output chan_four_pkg::drv_t drv_type_o,
   output logic [4:0] tail_ma_o,
   output logic [7:0] load_ohm_o,
   output logic [1:0] cmos_p_o,
   output logic [1:0] cmos_n_o
);
   import chan_four_pkg::*;

   logic [7:0] ctl_q; // Control register
   logic [DIV_WIDTH-1:0] div_q; // Divider register
   logic wr_pend_q; // Write data phase pending
   logic [31:0] wr_addr_q; // Address of pending write
   logic rd_go; // Read taken this cycle
   logic wr_go; // Write taken this cycle
   logic [7:0] ctl_view; // Control value with write forwarding
   logic [DIV_WIDTH-1:0] div_view; // Divider value with write forwarding
   src_t src; // Selected source
   drv_t drv; // Driver type
   logic [1:0] mode1; // First mode field
   logic [1:0] mode2; // Second mode field
   logic sel_tick; // Tick after source mux
   logic bypass; // Reference source skips the divider

   // Read data comes from flops loaded in the address phase, so no stall is needed
   // Never wait, never fail
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   // Address phase acceptance; only word accesses are expected
   // Size is ignored: a narrow write would still replace the whole field
   assign rd_go = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i && !hwrite_i;
   assign wr_go = hsel_i && htrans_i[HTRANS_ACTIVE_BIT] && hready_i && hwrite_i;

   // Capture write address so the data phase knows its target
   // Write data trails its address by one cycle on this bus
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end else begin
         wr_pend_q <= wr_go;
         if (wr_go) begin
            wr_addr_q <= haddr_i;
         end
      end
   end

   // Control register; write lands in the data phase
   // Reserved source code is stored as written; the mux keeps it quiet
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         ctl_q <= CTL_RST;
      end else if (wr_pend_q && wr_addr_q == CTL_ADDR) begin
         ctl_q <= hwdata_i[7:0];
      end
   end

   // Divider register
   // A smaller ratio wraps the counter at once rather than running on
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         div_q <= DIV_WIDTH'(DIV_RST);
      end else if (wr_pend_q && wr_addr_q == DIV_ADDR) begin
         div_q <= hwdata_i[DIV_WIDTH-1:0];
      end
   end

   // Forward a write in its data phase to a read right behind it
   // Without it a read straight after a write would return the stale value
   always_comb begin
      ctl_view = ctl_q;
      div_view = div_q;
      if (wr_pend_q && wr_addr_q == CTL_ADDR) begin
         ctl_view = hwdata_i[7:0];
      end
      if (wr_pend_q && wr_addr_q == DIV_ADDR) begin
         div_view = hwdata_i[DIV_WIDTH-1:0];
      end
   end

   // Read data registered at the address phase; unmapped reads zero
   // Zero for unmapped addresses keeps stale data off the bus
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         hrdata_o <= '0;
      end else if (rd_go) begin
         if (haddr_i == CTL_ADDR) begin
            hrdata_o <= 32'(ctl_view);
         end else if (haddr_i == DIV_ADDR) begin
            hrdata_o <= 32'(div_view);
         end else begin
            hrdata_o <= '0;
         end
      end
   end

   // Field split
   // Layout from the top: source, driver type, first mode, second mode
   assign src = src_t'(ctl_q[SRC_LSB +: 2]);
   assign drv = drv_t'(ctl_q[TYPE_LSB +: 2]);
   assign mode1 = ctl_q[MODE1_LSB +: 2];
   assign mode2 = ctl_q[MODE2_LSB +: 2];

   // Source selection
   // Reference sources come back with bypass set so the divider stands aside
   chan_source_mux u_mux (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .src_i(src),
      .dbl_en_i(dbl_en_i),
      .pll_tick_i(pll_tick_i),
      .pri_tick_i(pri_tick_i),
      .sec_tick_i(sec_tick_i),
      .pri_x2_tick_i(pri_x2_tick_i),
      .sec_x2_tick_i(sec_x2_tick_i),
      .tick_o(sel_tick),
      .bypass_o(bypass)
   );

   // Output divider
   // Runs on the shared clock; each source edge arrives as a one-cycle tick
   chan_divider #(
      .WIDTH(DIV_WIDTH)
   ) u_div (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .tick_i(sel_tick),
      .bypass_i(bypass),
      .div_i(div_q),
      .tick_o(chan_tick_o)
   );

   // Driver type and enable
   // Registered so the analog settings never see a decode glitch
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         drv_type_o <= DRV_OFF;
         drv_en_o <= 1'b0;
      end else begin
         drv_type_o <= drv;
         drv_en_o <= (drv != DRV_OFF);
      end
   end

   // Tail current: differential types only
   // Code three depends on the type, so type and mode are decoded together
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         tail_ma_o <= '0;
      end else if (drv == DRV_AC || drv == DRV_HCSL) begin
         case (mode1)
            2'h0: tail_ma_o <= TAIL_4MA;
            2'h1: tail_ma_o <= TAIL_6MA;
            2'h2: tail_ma_o <= TAIL_8MA;
            default: tail_ma_o <= (drv == DRV_HCSL) ? TAIL_16MA : TAIL_8MA;
         endcase
      end else begin
         tail_ma_o <= '0;
      end
   end

   // Load resistor: meaningful in HCSL only
   // Other types report tristate so no stray load value leaks out
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         load_ohm_o <= LOAD_OFF;
      end else if (drv == DRV_HCSL) begin
         case (mode2)
            2'h1: load_ohm_o <= LOAD_50;
            2'h2: load_ohm_o <= LOAD_100;
            2'h3: load_ohm_o <= LOAD_200;
            default: load_ohm_o <= LOAD_OFF;
         endcase
      end else begin
         load_ohm_o <= LOAD_OFF;
      end
   end

   // CMOS legs: 0 tristate, 1 low, 2 inverted, 3 true; tristate otherwise
   // Leg codes pass straight through; the pad logic interprets them
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cmos_p_o <= '0;
         cmos_n_o <= '0;
      end else if (drv == DRV_CMOS) begin
         cmos_p_o <= mode1;
         cmos_n_o <= mode2;
      end else begin
         cmos_p_o <= '0;
         cmos_n_o <= '0;
      end
   end

   // Register reset values, checked the cycle after reset is seen
   a_reset_values: assert property (@(posedge clk_i)
      !nrst_i |=> (ctl_q == CTL_RST && div_q == DIV_WIDTH'(DIV_RST)))
      else $error("reset values wrong");

   // Driver decode
   a_drv_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_OFF) |=> !drv_en_o)
      else $error("driver enabled while type is off");

   a_tail_hcsl: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_HCSL && mode1 == 2'h3) |=> (tail_ma_o == TAIL_16MA))
      else $error("HCSL code three tail not 16 mA");

   a_tail_ac: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_AC && mode1 == 2'h3) |=> (tail_ma_o == TAIL_8MA))
      else $error("AC code three tail not 8 mA");

   a_tail_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_AC && mode1 == 2'h0) |=> (tail_ma_o == TAIL_4MA))
      else $error("code zero tail not 4 mA");

   a_load_hcsl: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_HCSL && mode2 == 2'h2) |=> (load_ohm_o == LOAD_100))
      else $error("HCSL load not 100 ohm");

   a_cmos_legs: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_CMOS) |=> (cmos_p_o == $past(mode1) && cmos_n_o == $past(mode2)))
      else $error("CMOS legs do not follow mode fields");

   // Clock routing
   a_rsvd_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (src == SRC_RSVD) [*2] |-> !chan_tick_o)
      else $error("reserved source produced a tick");

   a_ref_bypass: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (src == SRC_PRI && !dbl_en_i && pri_tick_i) |=> chan_tick_o)
      else $error("reference source was divided");

   a_sec_bypass: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (src == SRC_SEC && !dbl_en_i && sec_tick_i) |=> chan_tick_o)
      else $error("secondary reference was divided");

   a_pll_divided: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (src == SRC_PLL) |-> !bypass)
      else $error("PLL source skipped the divider");

   // Ratio one passes every tick
   a_div_unity: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (src == SRC_PLL && div_q == '0 && pll_tick_i) |=> chan_tick_o)
      else $error("ratio one dropped a tick");

   // Remaining tail codes
   a_tail_six: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_HCSL && mode1 == 2'h1) |=> (tail_ma_o == TAIL_6MA))
      else $error("code one tail not 6 mA");

   a_tail_mid: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ((drv == DRV_AC || drv == DRV_HCSL) && mode1 == 2'h2) |=> (tail_ma_o == TAIL_8MA))
      else $error("code two tail not 8 mA");

   // No tail is reported for the off and CMOS types
   a_tail_none: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_OFF || drv == DRV_CMOS) |=> (tail_ma_o == '0))
      else $error("tail reported outside differential types");

   // Remaining load codes and the idle load
   a_load_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_HCSL && mode2 == 2'h1) |=> (load_ohm_o == LOAD_50))
      else $error("HCSL load not 50 ohm");

   a_load_top: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv == DRV_HCSL && mode2 == 2'h3) |=> (load_ohm_o == LOAD_200))
      else $error("HCSL load not 200 ohm");

   a_load_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv != DRV_HCSL) |=> (load_ohm_o == LOAD_OFF))
      else $error("load reported outside HCSL");

   // Legs idle and enable on outside their types
   a_cmos_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv != DRV_CMOS) |=> (cmos_p_o == '0 && cmos_n_o == '0))
      else $error("CMOS legs active outside CMOS type");

   a_drv_on: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (drv != DRV_OFF) |=> (drv_en_o && drv_type_o == $past(drv)))
      else $error("driver not enabled for its type");
endmodule : output_channel_four_control

// ---- output_channel_four_control_test.sv ----
// Self-checking bench for the channel four control block
`timescale 1ns/1ps
module output_channel_four_control_test;
   import chan_four_pkg::*;
   logic clk_i, nrst_i, hsel_i, hwrite_i, dbl_en_i; // Bench-driven controls
   logic [1:0] htrans_i; // Transfer type
   logic [31:0] haddr_i, hwdata_i; // Address and write data
   logic [4:0] ticks; // pll, pri, sec, pri x2, sec x2
   wire logic [31:0] hrdata_o; // Read data
   wire logic hreadyout_o, hresp_o, chan_tick_o, drv_en_o; // Slave answers
   drv_t drv_type_o; // Driver type output
   logic [4:0] tail_ma_o; // Tail current
   logic [7:0] load_ohm_o; // HCSL load
   logic [1:0] cmos_p_o, cmos_n_o; // CMOS legs
   int mismatches = 0; // Failed compares
   int tests_run = 0; // All compares
   output_channel_four_control uut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .dbl_en_i(dbl_en_i),
      .pll_tick_i(ticks[4]), .pri_tick_i(ticks[3]), .sec_tick_i(ticks[2]), .pri_x2_tick_i(ticks[1]),
      .sec_x2_tick_i(ticks[0]), .chan_tick_o(chan_tick_o), .drv_en_o(drv_en_o), .drv_type_o(drv_type_o),
      .tail_ma_o(tail_ma_o), .load_ohm_o(load_ohm_o), .cmos_p_o(cmos_p_o), .cmos_n_o(cmos_n_o));
   // Free-running bus clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // Verdict, reached from the main sequence or the watchdog
   task automatic close_out;
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   // Case-equal compare with a report on mismatch
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One bus transfer; waits on hready in both phases, only the watchdog ends a wait
   task automatic xfer(input logic is_wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      htrans_i <= 2'h2;
      hwrite_i <= is_wr;
      do begin
         @(posedge clk_i);
      end while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      do begin
         @(posedge clk_i);
      end while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
      chk({31'h0, hresp_o}, 32'h0);
   endtask : xfer
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] x;
      xfer(1'b1, a, {24'h0, d}, x);
   endtask : wr
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0, x);
      chk(x, exp);
   endtask : rd_chk
   // Counts channel ticks over a window once the given source ticks run every cycle
   task automatic count_ticks(input logic [4:0] mask, input int cyc, input int exp);
      int n;
      n = 0;
      @(posedge clk_i);
      ticks <= mask;
      repeat (4) @(posedge clk_i);
      repeat (cyc) begin
         @(posedge clk_i);
         if (chan_tick_o === 1'b1) n++;
      end
      ticks <= 5'h0;
      repeat (4) @(posedge clk_i);
      chk(32'(n), 32'(exp));
   endtask : count_ticks
   // Expected driver outputs as {en, type, tail, load, p leg, n leg}
   function automatic logic [19:0] exp_drv(input logic [1:0] t, input logic [1:0] m1, input logic [1:0] m2);
      logic [4:0] tl;
      logic [7:0] ld;
      logic [3:0] legs;
      tl = 5'h00;
      ld = LOAD_OFF;
      legs = 4'h0;
      if (t == 2'h1 || t == 2'h2) begin
         case (m1)
            2'h0: tl = TAIL_4MA;
            2'h1: tl = TAIL_6MA;
            2'h2: tl = TAIL_8MA;
            default: tl = (t == 2'h2) ? TAIL_16MA : TAIL_8MA;
         endcase
      end
      if (t == 2'h2) begin
         case (m2)
            2'h0: ld = LOAD_OFF;
            2'h1: ld = LOAD_50;
            2'h2: ld = LOAD_100;
            default: ld = LOAD_200;
         endcase
      end
      if (t == 2'h3) legs = {m1, m2};
      return {t != 2'h0, t, tl, ld, legs};
   endfunction : exp_drv
   // Reset for three cycles, then reset values at the registers and outputs
   task automatic do_reset;
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({12'h0, drv_en_o, drv_type_o, tail_ma_o, load_ohm_o, cmos_p_o, cmos_n_o}, {12'h0, exp_drv(2'h1, 2'h2, 2'h0)});
      rd_chk(CTL_ADDR, 32'h18);
      rd_chk(DIV_ADDR, 32'h02);
   endtask : do_reset
   // Every driver type with every mode pair, plus read-back
   task automatic drv_table;
      for (int i = 0; i < 64; i++) begin
         wr(CTL_ADDR, 8'(i));
         repeat (2) @(posedge clk_i);
         chk({12'h0, drv_en_o, drv_type_o, tail_ma_o, load_ohm_o, cmos_p_o, cmos_n_o}, {12'h0, exp_drv(2'(i >> 4), 2'(i >> 2), 2'(i))});
      end
      rd_chk(CTL_ADDR, 32'h3f);
      rd_chk(32'h0000_0100, 32'h0);
   endtask : drv_table
   // PLL source: one output per div+1 ticks, boundary ratios included
   task automatic div_ratios;
      logic [7:0] dv[4] = '{8'h00, 8'h01, 8'h02, 8'hff};
      wr(CTL_ADDR, 8'h18);
      foreach (dv[k]) begin
         wr(DIV_ADDR, dv[k]);
         rd_chk(DIV_ADDR, {24'h0, dv[k]});
         count_ticks(5'b10000, 4 * (int'(dv[k]) + 1), 4);
      end
   endtask : div_ratios
   // References bypass the divider; doubler and reserved code
   task automatic bypass_paths;
      wr(CTL_ADDR, 8'h98);
      count_ticks(5'b01000, 8, 8);
      count_ticks(5'b10000, 8, 0);
      wr(CTL_ADDR, 8'hd8);
      count_ticks(5'b00100, 8, 8);
      @(posedge clk_i);
      dbl_en_i <= 1'b1;
      count_ticks(5'b00001, 8, 8);
      count_ticks(5'b00100, 8, 0);
      wr(CTL_ADDR, 8'h98);
      count_ticks(5'b00010, 8, 8);
      @(posedge clk_i);
      dbl_en_i <= 1'b0;
      wr(CTL_ADDR, 8'h58);
      count_ticks(5'b11111, 16, 0);
   endtask : bypass_paths
   // Main sequence
   initial begin
      nrst_i = 1'b0;
      hsel_i = 1'b0;
      haddr_i = 32'h0;
      htrans_i = 2'h0;
      hwrite_i = 1'b0;
      hwdata_i = 32'h0;
      dbl_en_i = 1'b0;
      ticks = 5'h0;
      do_reset();
      drv_table();
      div_ratios();
      bypass_paths();
      do_reset();
      close_out();
   end
   // Watchdog well beyond the 1600 or so cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      close_out();
   end
endmodule : output_channel_four_control_test
